// ---- logic/tslr_top.sv ----
// file: status, limit, hysteresis and identity registers behind a two-wire slave
`timescale 1ns/1ps
module tslr_top
  import tslr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR       = 7'h4c,
  parameter logic [7:0] MAKER_CODE     = 8'h5a, // arbitrary value
  parameter logic [7:0] DIE_REVISION   = 8'h21, // arbitrary value
  parameter int         POWERUP_CYCLES_P = POWERUP_CYCLES
)
(
  input  wire logic       CLK_I,
  input  wire logic       RESET_I,
  input  wire logic       SCL_I,
  input  wire logic       SDA_I,
  output logic            SDA_O,
  output logic            SDA_OE_N_O,
  input  wire logic       BUSY_I,
  input  wire logic       DIODE_FAULT_I,
  input  wire logic [7:0] REMOTE_TEMP_I,
  input  wire logic [7:0] REMOTE_SIGNED_I,
  input  wire logic [7:0] LOCAL_TEMP_I,
  output logic [7:0]      REMOTE_UNSIGNED_O,
  output logic [7:0]      REMOTE_SIGNED_O,
  output logic            OVERTEMP_SHUTDOWN_OUTPUT_O,
  output logic            CRITICAL_TEMP_OUTPUT_O
);

  localparam int PCW = $clog2(POWERUP_CYCLES_P + 1);

  // ==========================================================
  // declarations
  logic                  scl_q;
  logic                  sda_q;
  logic                  bus_start;
  logic                  bus_stop;
  logic                  scl_rise;
  logic                  scl_fall;
  tslr_bus_state_t       bstate;
  logic [2:0]            bit_cnt;
  logic [7:0]            shreg;
  logic [7:0]            tx;
  logic                  rd_mode;
  logic                  more;
  logic [7:0]            ptr;
  logic                  wr_stb;
  logic [7:0]            wr_data;
  logic [7:0]            remote_overtemp_limit;
  logic [7:0]            remote_crit_limit;
  logic [7:0]            local_limit;
  logic [HYST_WIDTH-1:0] hyst;
  logic [7:0]            diode_cfg;
  logic                  busy_q;
  logic                  fault_q;
  logic                  not_ready;
  logic [PCW-1:0]        pwr_cnt;
  tslr_flags_t           flags;
  logic [7:0]            status_primary;
  logic [7:0]            status_secondary;
  logic [7:0]            rd_byte;

  // ==========================================================
  // comparators
  tslr_hyst_cmp #(.W(8)) u_cmp_remote_os (
    .clk_i   (CLK_I),
    .rst_i   (RESET_I),
    .temp_i  (REMOTE_TEMP_I),
    .limit_i (remote_overtemp_limit),
    .hyst_i  (hyst),
    .flag_o  (flags.remote_os)
  );

  tslr_hyst_cmp #(.W(8)) u_cmp_remote_crit (
    .clk_i   (CLK_I),
    .rst_i   (RESET_I),
    .temp_i  (REMOTE_TEMP_I),
    .limit_i (remote_crit_limit),
    .hyst_i  (hyst),
    .flag_o  (flags.remote_crit)
  );

  tslr_hyst_cmp #(.W(8)) u_cmp_local (
    .clk_i   (CLK_I),
    .rst_i   (RESET_I),
    .temp_i  (LOCAL_TEMP_I),
    .limit_i (local_limit),
    .hyst_i  (hyst),
    .flag_o  (flags.local_lim)
  );

  // ==========================================================
  // status composition
  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      busy_q  <= 1'b0;
      fault_q <= 1'b0;
    end
    else
    begin
      busy_q  <= BUSY_I;
      fault_q <= DIODE_FAULT_I;
    end
  end

  always_comb
  begin
    status_primary                      = 8'h00; // R2
    status_primary[STAT1_BUSY_BIT]      = busy_q; // R1
    status_primary[STAT1_REMOTE_OS_BIT] = flags.remote_os; // R3
    status_primary[STAT1_FAULT_BIT]     = fault_q; // R4
    status_primary[STAT1_REMOTE_CR_BIT] = flags.remote_crit; // R6
    status_primary[STAT1_LOCAL_BIT]     = flags.local_lim; // R7
    status_secondary                    = 8'h00; // R9
    status_secondary[STAT2_NOT_READY_BIT] = not_ready; // R8
  end

  // ==========================================================
  // power-up sequence timer
  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      pwr_cnt   <= '0;
      not_ready <= 1'b1;
    end
    else if (not_ready)
    begin
      pwr_cnt <= pwr_cnt + PCW'(1);
      if (pwr_cnt == PCW'(POWERUP_CYCLES_P - 1))
        not_ready <= 1'b0; // R8
    end
  end

  // ==========================================================
  // register read decode
  function automatic logic [7:0] read_reg(input logic [7:0] addr);
    case (addr)
      REG_STATUS_PRIMARY:   read_reg = status_primary;
      REG_STATUS_SECONDARY: read_reg = status_secondary;
      REG_REMOTE_OVERTEMP_LIMIT:  read_reg = remote_overtemp_limit;
      REG_REMOTE_CRIT_LIM:  read_reg = remote_crit_limit;
      REG_LOCAL_LIMIT:      read_reg = local_limit;
      REG_HYSTERESIS:       read_reg = {3'h0, hyst}; // R13
      REG_DIODE_CONFIG:     read_reg = {1'b0, diode_cfg[6:1], 1'b1};
      REG_MAKER_CODE:       read_reg = MAKER_CODE; // R14
      REG_DIE_REVISION:     read_reg = DIE_REVISION; // R15
      default:              read_reg = 8'h00;
    endcase
  endfunction

  // a function result cannot be bit-selected, so the addressed byte is held here
  always_comb
  begin
    rd_byte = read_reg(ptr);
  end

  // ==========================================================
  // register writes; read-only offsets ignore writes
  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      remote_overtemp_limit   <= RST_REMOTE_OVERTEMP_LIMIT; // R10
      remote_crit_limit <= RST_REMOTE_CRIT_LIM; // R12
      local_limit       <= RST_LOCAL_LIMIT; // R11
      hyst              <= RST_HYSTERESIS; // R13
      diode_cfg         <= RST_DIODE_CONFIG;
    end
    else if (wr_stb)
    begin
      case (ptr)
        REG_REMOTE_OVERTEMP_LIMIT: remote_overtemp_limit   <= wr_data; // R10
        REG_REMOTE_CRIT_LIM: remote_crit_limit <= wr_data; // R12
        REG_LOCAL_LIMIT:     local_limit       <= wr_data; // R11
        REG_HYSTERESIS:      hyst              <= wr_data[HYST_WIDTH-1:0]; // R13
        REG_DIODE_CONFIG:    diode_cfg         <= wr_data; // R17
        default:             ;
      endcase
    end
  end

  // ==========================================================
  // two-wire slave: line events
  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= SCL_I;
      sda_q <= SDA_I;
    end
  end

  assign bus_start = SCL_I & scl_q & sda_q & ~SDA_I;
  assign bus_stop  = SCL_I & scl_q & ~sda_q & SDA_I;
  assign scl_rise  = SCL_I & ~scl_q;
  assign scl_fall  = ~SCL_I & scl_q;

  // ==========================================================
  // two-wire slave: byte engine
  // data changes only on scl falling edges, so start/stop never alias
  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      bstate     <= BS_IDLE;
      bit_cnt    <= 3'h0;
      shreg      <= 8'h00;
      tx         <= 8'h00;
      rd_mode    <= 1'b0;
      more       <= 1'b0;
      ptr        <= 8'h00;
      wr_stb     <= 1'b0;
      wr_data    <= 8'h00;
      SDA_OE_N_O <= 1'b1;
    end
    else
    begin
      wr_stb <= 1'b0;
      if (bus_stop)
      begin
        bstate     <= BS_IDLE;
        SDA_OE_N_O <= 1'b1;
      end
      else if (bus_start)
      begin
        bstate     <= BS_ADDR;
        bit_cnt    <= 3'h0;
        SDA_OE_N_O <= 1'b1;
      end
      else
      begin
        case (bstate)
          BS_IDLE: ;
          BS_ADDR, BS_PTR, BS_WDATA:
          begin
            if (scl_rise)
            begin
              shreg   <= {shreg[6:0], SDA_I};
              bit_cnt <= bit_cnt + 3'h1;
              if (bit_cnt == 3'h7)
              begin
                if (bstate == BS_ADDR)
                begin
                  if (shreg[6:0] == DEV_ADDR)
                  begin
                    bstate  <= BS_ADDR_ACK;
                    rd_mode <= SDA_I;
                  end
                  else
                    bstate <= BS_IDLE;
                end
                else if (bstate == BS_PTR)
                begin
                  bstate <= BS_PTR_ACK;
                  ptr    <= {shreg[6:0], SDA_I};
                end
                else
                begin
                  bstate  <= BS_WDATA_ACK;
                  wr_stb  <= 1'b1;
                  wr_data <= {shreg[6:0], SDA_I};
                end
              end
            end
          end
          BS_ADDR_ACK, BS_PTR_ACK, BS_WDATA_ACK:
          begin
            // first fall after the eighth bit pulls the line low, second one ends the ack
            if (scl_fall)
            begin
              if (SDA_OE_N_O)
                SDA_OE_N_O <= 1'b0;
              else if (bstate == BS_ADDR_ACK && rd_mode)
              begin
                tx         <= {rd_byte[6:0], 1'b0};
                SDA_OE_N_O <= rd_byte[7];
                bit_cnt    <= 3'h0;
                bstate     <= BS_RDATA;
              end
              else
              begin
                SDA_OE_N_O <= 1'b1;
                bit_cnt    <= 3'h0;
                bstate     <= (bstate == BS_ADDR_ACK) ? BS_PTR : BS_WDATA;
              end
            end
          end
          BS_RDATA:
          begin
            if (scl_fall)
            begin
              bit_cnt <= bit_cnt + 3'h1;
              if (bit_cnt == 3'h7)
              begin
                SDA_OE_N_O <= 1'b1;
                bstate     <= BS_RACK;
              end
              else
              begin
                SDA_OE_N_O <= tx[7];
                tx         <= {tx[6:0], 1'b0};
              end
            end
          end
          BS_RACK:
          begin
            if (scl_rise)
              more <= ~SDA_I;
            else if (scl_fall)
            begin
              if (more)
              begin
                tx         <= {rd_byte[6:0], 1'b0};
                SDA_OE_N_O <= rd_byte[7];
                bit_cnt    <= 3'h0;
                bstate     <= BS_RDATA;
              end
              else
                bstate <= BS_IDLE;
            end
          end
          default: bstate <= BS_IDLE;
        endcase
      end
    end
  end

  // open drain: the data level is always low, only the enable moves
  always_ff @(posedge CLK_I)
  begin
    SDA_O <= 1'b0;
  end

  // ==========================================================
  // results substitute and alarm outputs
  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      REMOTE_UNSIGNED_O          <= FAULT_UNSIGNED_VALUE;
      REMOTE_SIGNED_O            <= FAULT_SIGNED_VALUE;
      OVERTEMP_SHUTDOWN_OUTPUT_O <= 1'b0;
      CRITICAL_TEMP_OUTPUT_O     <= 1'b0;
    end
    else
    begin
      REMOTE_UNSIGNED_O <= fault_q ? FAULT_UNSIGNED_VALUE : REMOTE_TEMP_I; // R5
      REMOTE_SIGNED_O   <= fault_q ? FAULT_SIGNED_VALUE : REMOTE_SIGNED_I; // R5
      OVERTEMP_SHUTDOWN_OUTPUT_O <= flags.remote_os | flags.local_lim // R7
        | (fault_q & ~diode_cfg[CFG_OS_FAULT_MASK]); // R17
      CRITICAL_TEMP_OUTPUT_O <= flags.remote_crit | flags.local_lim // R7
        | (fault_q & ~diode_cfg[CFG_CRIT_FAULT_MASK]); // R17
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);

  property p_busy_bit;
    BUSY_I |=> status_primary[STAT1_BUSY_BIT] ##1 1'b1;
  endproperty
  a_busy_bit: assert property (p_busy_bit) // R1
    else $error("busy bit missed conversion");

  property p_stat1_zero;
    status_primary[6:5] == 2'b00 && !status_primary[3];
  endproperty
  a_stat1_zero: assert property (p_stat1_zero) // R2
    else $error("unused status bits not zero");

  property p_fault_bit;
    $rose(DIODE_FAULT_I) |=> status_primary[STAT1_FAULT_BIT];
  endproperty
  a_fault_bit: assert property (p_fault_bit) // R4
    else $error("fault bit not set");

  property p_fault_result;
    fault_q |=> REMOTE_UNSIGNED_O == FAULT_UNSIGNED_VALUE
             && REMOTE_SIGNED_O == FAULT_SIGNED_VALUE;
  endproperty
  a_fault_result: assert property (p_fault_result) // R5
    else $error("result not forced during fault");

  property p_local_both;
    flags.local_lim |=> OVERTEMP_SHUTDOWN_OUTPUT_O && CRITICAL_TEMP_OUTPUT_O;
  endproperty
  a_local_both: assert property (p_local_both) // R7
    else $error("local flag not on both outputs");

  property p_not_ready;
    (pwr_cnt < PCW'(POWERUP_CYCLES_P - 1)) |-> status_secondary[STAT2_NOT_READY_BIT];
  endproperty
  a_not_ready: assert property (p_not_ready) // R8
    else $error("ready reported too early");

  property p_ready_end;
    (pwr_cnt == PCW'(POWERUP_CYCLES_P - 1)) |=> !not_ready ##1 !not_ready;
  endproperty
  a_ready_end: assert property (p_ready_end) // R8
    else $error("not-ready did not clear at end");

  property p_stat2_zero;
    status_secondary[6:0] == 7'h00;
  endproperty
  a_stat2_zero: assert property (p_stat2_zero) // R9
    else $error("status_secondary low bits not zero");

  property p_os_write;
    (wr_stb && ptr == REG_REMOTE_OVERTEMP_LIMIT) |=> remote_overtemp_limit == $past(wr_data);
  endproperty
  a_os_write: assert property (p_os_write) // R10
    else $error("overtemp limit write lost");

  property p_hyst_read;
    (read_reg(REG_HYSTERESIS) & 8'he0) == 8'h00;
  endproperty
  a_hyst_read: assert property (p_hyst_read) // R13
    else $error("hysteresis upper bits not zero");

  property p_ids;
    read_reg(REG_MAKER_CODE) == MAKER_CODE && read_reg(REG_DIE_REVISION) == DIE_REVISION;
  endproperty
  a_ids: assert property (p_ids) // R14
    else $error("identity register changed");

  property p_fault_mask_os;
    (fault_q && !diode_cfg[CFG_OS_FAULT_MASK]) |=> OVERTEMP_SHUTDOWN_OUTPUT_O;
  endproperty
  a_fault_mask_os: assert property (p_fault_mask_os) // R17
    else $error("unmasked fault not on shutdown output");

  c_write: cover property (wr_stb && ptr == REG_REMOTE_CRIT_LIM);
  c_read: cover property (bstate == BS_RACK && more);
  c_ready: cover property ($fell(not_ready));

endmodule

// ---- pkg/tslr_pkg.sv ----
// package: constants and types for the thermal status and limit register bank
//
// Overview of operation
// R1 - status_primary bit 7 is one while a conversion runs, else zero.
// R2 - status_primary bits 6, 5 and 3 always read zero.
// R3 - status_primary bit 4 shows the remote overtemperature comparison.
// R4 - status_primary bit 2 shows a missing or shorted remote diode.
// R5 - during a diode fault, unsigned results read zero, signed results read minimum.
// R6 - status_primary bit 1 shows the remote critical comparison.
// R7 - status_primary bit 0 shows the local comparison, shared by both outputs.
// R8 - status_secondary bit 7 reads one until the 30 ms power-up ends.
// R9 - status_secondary bit 6 may read either value; bits 5 to 0 read zero.
// R10 - remote overtemperature limit is read/write, 8-bit, resets to 85 degrees.
// R11 - local shared limit is read/write, 8-bit, resets to 85 degrees.
// R12 - remote critical limit is read/write, 8-bit, resets to 110 degrees.
// R13 - hysteresis holds five bits, upper three read zero, resets to 10.
// R14 - maker code register is read-only and returns one fixed value.
// R15 - die revision register is read-only and returns the revision code.
// R16 - software enables transistor compensation only for grounded-collector sensors.
// R17 - configuration holds separate fault masks for shutdown and critical outputs.
// R18 - limit flags set above limit, clear below limit minus hysteresis.
package tslr_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] REG_STATUS_PRIMARY   = 8'h02;
  localparam logic [7:0] REG_REMOTE_OVERTEMP_LIMIT  = 8'h07;
  localparam logic [7:0] REG_REMOTE_CRIT_LIM  = 8'h19;
  localparam logic [7:0] REG_LOCAL_LIMIT      = 8'h20;
  localparam logic [7:0] REG_HYSTERESIS       = 8'h21;
  localparam logic [7:0] REG_STATUS_SECONDARY = 8'h33;
  localparam logic [7:0] REG_DIODE_CONFIG     = 8'hbf;
  localparam logic [7:0] REG_MAKER_CODE       = 8'hfe;
  localparam logic [7:0] REG_DIE_REVISION     = 8'hff;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_REMOTE_OVERTEMP_LIMIT = 8'h55;
  localparam logic [7:0] RST_REMOTE_CRIT_LIM = 8'h6e;
  localparam logic [7:0] RST_LOCAL_LIMIT     = 8'h55;
  localparam logic [4:0] RST_HYSTERESIS      = 5'h0a;
  localparam logic [7:0] RST_DIODE_CONFIG    = 8'h1f;

  // ==========================================================
  // field positions
  localparam int STAT1_BUSY_BIT      = 7;
  localparam int STAT1_REMOTE_OS_BIT = 4;
  localparam int STAT1_FAULT_BIT     = 2;
  localparam int STAT1_REMOTE_CR_BIT = 1;
  localparam int STAT1_LOCAL_BIT     = 0;
  localparam int STAT2_NOT_READY_BIT = 7;
  localparam int CFG_OS_FAULT_MASK   = 5;
  localparam int CFG_CRIT_FAULT_MASK = 4;
  localparam int HYST_WIDTH          = 5;

  // ==========================================================
  // fault substitutes for result values
  localparam logic [7:0] FAULT_UNSIGNED_VALUE = 8'h00;
  localparam logic [7:0] FAULT_SIGNED_VALUE   = 8'h80;

  // ==========================================================
  // timing
  localparam int CLK_HZ         = 40_000_000;
  localparam int POWERUP_MS     = 30;
  localparam int POWERUP_CYCLES = POWERUP_MS * (CLK_HZ / 1000);

  // ==========================================================
  // bus slave states and flag bundle
  typedef enum logic [3:0] {
    BS_IDLE, BS_ADDR, BS_ADDR_ACK, BS_PTR, BS_PTR_ACK,
    BS_WDATA, BS_WDATA_ACK, BS_RDATA, BS_RACK
  } tslr_bus_state_t;

  typedef struct packed {
    logic local_lim;
    logic remote_crit;
    logic remote_os;
  } tslr_flags_t;

endpackage

// ---- logic/tslr_hyst_cmp.sv ----
// file: limit comparator with hysteresis for one temperature channel
`timescale 1ns/1ps
module tslr_hyst_cmp
  import tslr_pkg::*;
#(
  parameter int W = 8
)
(
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic [W-1:0]          temp_i,
  input  wire logic [W-1:0]          limit_i,
  input  wire logic [HYST_WIDTH-1:0] hyst_i,
  output logic                       flag_o
);

  logic [W-1:0] release_level;

  // saturate at zero so a small limit never wraps the release point upward
  function automatic logic [W-1:0] sat_sub(input logic [W-1:0] a,
                                           input logic [HYST_WIDTH-1:0] b);
    logic [W-1:0] bw;
    bw = W'(b);
    sat_sub = (a > bw) ? a - bw : '0;
  endfunction

  always_comb
  begin
    release_level = sat_sub(limit_i, hyst_i);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      flag_o <= 1'b0;
    else if (temp_i > limit_i)
      flag_o <= 1'b1; // R18
    else if (temp_i < release_level)
      flag_o <= 1'b0; // R18
  end

  // ==========================================================
  // assertions
  property p_flag_set;
    @(posedge clk_i) disable iff (rst_i)
      (temp_i > limit_i) |=> flag_o;
  endproperty
  a_flag_set: assert property (p_flag_set) // R18
    else $error("flag did not set above limit");

  property p_flag_hold;
    @(posedge clk_i) disable iff (rst_i)
      (flag_o && temp_i >= sat_sub(limit_i, hyst_i)) |=> flag_o;
  endproperty
  a_flag_hold: assert property (p_flag_hold) // R18
    else $error("flag cleared inside hysteresis band");

  c_flag_rise: cover property (@(posedge clk_i) disable iff (rst_i) $rose(flag_o));

endmodule

// ---- test/tslr_host.sv ----
// two-wire bus master model standing in for the host processor
`timescale 1ns/1ps
module tslr_host
  import tslr_pkg::*;
#(
  parameter logic [6:0] ADDR = 7'h4c,
  parameter int         HALF = 4
)
(
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  // =====
  // bit level; lines move just after an edge, released sda is pulled high
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic hold();
    repeat (HALF) @(posedge clk_i);
  endtask

  // also serves as a repeated start from scl low
  task automatic start();
    sda_o <= 1'b1;
    hold();
    scl_o <= 1'b1;
    hold();
    sda_o <= 1'b0;
    hold();
    scl_o <= 1'b0;
    hold();
  endtask

  task automatic stop();
    sda_o <= 1'b0;
    hold();
    scl_o <= 1'b1;
    hold();
    sda_o <= 1'b1;
    hold();
  endtask

  task automatic bit_io(input logic b, output logic r);
    sda_o <= b;
    hold();
    scl_o <= 1'b1;
    hold();
    r = sda_i;
    scl_o <= 1'b0;
    hold();
  endtask

  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
                      output logic r);
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(d[i], q[i]);
    end
    bit_io(a, r);
  endtask

  // =====
  // register transfers; ok is low if the slave left any address, pointer or write byte unacknowledged
  task automatic write_reg(input logic [7:0] ptr, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic       a0;
    logic       a1;
    logic       a2;
    start();
    xfer({ADDR, 1'b0}, 1'b1, q, a0);
    xfer(ptr, 1'b1, q, a1);
    xfer(d, 1'b1, q, a2);
    stop();
    ok = !(a0 | a1 | a2);
  endtask

  task automatic read_reg(input logic [7:0] ptr, output logic [7:0] q, output logic ok);
    logic [7:0] d;
    logic       a0;
    logic       a1;
    logic       a2;
    logic       na;
    start();
    xfer({ADDR, 1'b0}, 1'b1, d, a0);
    xfer(ptr, 1'b1, d, a1);
    start();
    xfer({ADDR, 1'b1}, 1'b1, d, a2);
    xfer(8'hff, 1'b1, q, na);
    stop();
    ok = !(a0 | a1 | a2);
  endtask

  // current-pointer read of two bytes; the ack after the first asks for the same offset again
  task automatic read_twice(output logic [7:0] q0, output logic [7:0] q1, output logic ok);
    logic [7:0] d;
    logic       a0;
    logic       na;
    start();
    xfer({ADDR, 1'b1}, 1'b1, d, a0);
    xfer(8'hff, 1'b0, q0, na);
    xfer(8'hff, 1'b1, q1, na);
    stop();
    ok = !a0;
  endtask
endmodule

// ---- test/thermal_status_limit_registers_tb.sv ----
// self-checking bench for the thermal status and limit register bank
`timescale 1ns/1ps
module thermal_status_limit_registers_tb;
  import tslr_pkg::*;
  localparam int         PU    = 2000;
  localparam logic [7:0] MAKER = 8'h3c; // arbitrary value
  localparam logic [7:0] REV   = 8'h47; // arbitrary value
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       busy = 1'b0;
  logic       fault = 1'b0;
  logic [7:0] rtemp = 8'h10;
  logic [7:0] rsig = 8'h19;
  logic [7:0] ltemp = 8'h10;
  logic       scl;
  logic       host_sda;
  logic       sda_o;
  logic       sda_oe_n;
  logic       os_out;
  logic       crit_out;
  logic [7:0] uns;
  logic [7:0] sgn;
  logic       ok;
  logic [7:0] q;
  logic [7:0] q2;
  wire        sda = host_sda & (sda_oe_n | sda_o);
  int         bad_count = 0;
  int         total_checks = 0;

  initial
  begin
    forever #12.5 clk = ~clk;
  end

  tslr_top #(.MAKER_CODE(MAKER), .DIE_REVISION(REV), .POWERUP_CYCLES_P(PU)) u_dut (
    .CLK_I(clk), .RESET_I(rst), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o),
    .SDA_OE_N_O(sda_oe_n), .BUSY_I(busy), .DIODE_FAULT_I(fault),
    .REMOTE_TEMP_I(rtemp), .REMOTE_SIGNED_I(rsig), .LOCAL_TEMP_I(ltemp),
    .REMOTE_UNSIGNED_O(uns), .REMOTE_SIGNED_O(sgn),
    .OVERTEMP_SHUTDOWN_OUTPUT_O(os_out), .CRITICAL_TEMP_OUTPUT_O(crit_out));

  tslr_host u_host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(host_sda));

  // =====
  // helpers
  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
      bad_count++;
    end
  endtask

  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    u_host.write_reg(ptr, d, ok);
    chk(8'h01, {7'h00, ok});
  endtask

  task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
    u_host.read_reg(ptr, q, ok);
    chk(8'h01, {7'h00, ok});
    chk(exp, q);
  endtask

  // inputs change at an edge, then the two-cycle pipeline settles
  task automatic drive(input logic b, input logic f, input logic [7:0] rt,
                       input logic [7:0] lt);
    @(posedge clk);
    busy <= b;
    fault <= f;
    rtemp <= rt;
    ltemp <= lt;
    repeat (4) @(posedge clk);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // =====
  // scenarios
  task automatic t_reset_values();
    rd(8'h33, 8'h80);
    rd(8'h07, 8'h55);
    rd(8'h20, 8'h55);
    rd(8'h19, 8'h6e);
    rd(8'h21, 8'h0a);
    rd(8'hfe, MAKER);
    rd(8'hff, REV);
  endtask

  // pointer kept from the last read; master ack fetches the same offset twice
  task automatic t_burst_read();
    u_host.read_twice(q, q2, ok);
    chk(8'h01, {7'h00, ok});
    chk(REV, q);
    chk(REV, q2);
  endtask

  task automatic t_power_up();
    repeat (PU) @(posedge clk);
    rd(8'h33, 8'h00);
  endtask

  task automatic t_limits_rw();
    wr(8'h07, 8'hc8);
    rd(8'h07, 8'hc8);
    wr(8'h20, 8'h7f);
    rd(8'h20, 8'h7f);
    wr(8'h19, 8'hff);
    rd(8'h19, 8'hff);
    wr(8'h21, 8'hff);
    rd(8'h21, 8'h1f);
    wr(8'hfe, 8'h00);
    rd(8'hfe, MAKER);
    wr(8'hff, 8'h00);
    rd(8'hff, REV);
  endtask

  task automatic t_status_fault();
    drive(1'b1, 1'b0, 8'h10, 8'h10);
    rd(8'h02, 8'h80);
    drive(1'b0, 1'b1, 8'h10, 8'h10);
    rd(8'h02, 8'h04);
    chk(8'h00, uns);
    chk(8'h80, sgn);
    chk(8'h01, {7'h00, os_out});
    chk(8'h00, {7'h00, crit_out});
    // compensation select stays set: the remote sensor is a grounded-collector part
    wr(8'hbf, 8'h0f);
    chk(8'h01, {7'h00, crit_out});
    wr(8'hbf, 8'h3f);
    chk(8'h00, {6'h00, os_out, crit_out});
    drive(1'b0, 1'b0, 8'h10, 8'h10);
    chk(8'h10, uns);
    chk(8'h19, sgn);
  endtask

  task automatic t_flags();
    wr(8'h07, 8'h40);
    wr(8'h19, 8'h60);
    wr(8'h20, 8'h50);
    wr(8'h21, 8'h05);
    drive(1'b0, 1'b0, 8'h41, 8'h10);
    rd(8'h02, 8'h10);
    chk(8'h02, {6'h00, os_out, crit_out});
    drive(1'b0, 1'b0, 8'h61, 8'h10);
    rd(8'h02, 8'h12);
    chk(8'h03, {6'h00, os_out, crit_out});
    drive(1'b0, 1'b0, 8'h3c, 8'h10);
    rd(8'h02, 8'h10);
    drive(1'b0, 1'b0, 8'h3a, 8'h10);
    rd(8'h02, 8'h00);
    drive(1'b0, 1'b0, 8'h3a, 8'h51);
    rd(8'h02, 8'h01);
    chk(8'h03, {6'h00, os_out, crit_out});
  endtask

  initial
  begin
    repeat (100000) @(posedge clk);
    bad_count++;
    end_sim();
  end

  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_reset_values();
    t_burst_read();
    t_power_up();
    t_limits_rw();
    t_status_fault();
    t_flags();
    end_sim();
  end
endmodule
